//--- common/irq_arb_pkg.sv
// Constants and register map of the interrupt arbiter
// How it works
// - Software sets each source to one of four levels; sources 0 and 1 are fixed.
// - Within a level the lowest-numbered active source wins; 0 highest, 81 lowest.
// - Ordinary vector address is vector base concatenated with the source number.
// - Core mask 00 allows all levels, 01 blocks 0, 10 blocks 0-1, 11 only 3.
// - Current level code 00 none, 01 level 0, 10 level 1, 11 level 2/3.
// - A source is fast only if it matches a fast match register and has level 2.
// - A fast source gets the address from its fast low/high pair instead.
// - In wait or stop, any pending request from a source enabled at entry asks the system logic to wake.
// - Only sources enabled before wait or stop entry may cause wake-up.
// - In wait or stop both external pins act low-level, ignoring edge mode.
// - After reset the initial program address is driven on the address bus.
// - Priority, base, match and address registers are reachable as a bus slave.
// - Interrupt is signalled only for sufficient priority, with its vector address.
package irq_arb_pkg;
  localparam int         NUM_SRC     = 82;
  localparam int         FIXED_SRC   = 2;
  localparam logic [1:0] FIXED_LVL   = 2'h3;
  localparam int         EXT_A_SRC   = 2;
  localparam int         EXT_B_SRC   = 3;
  localparam int         FAST_LVL    = 2;
  localparam int         VEC_W       = 7;
  localparam int         VADDR_W     = 21;
  localparam int         BASE_W      = VADDR_W - VEC_W;
  localparam logic [VADDR_W-1:0] RESET_ADDR = 21'h000000;
  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_PRIO0   = 5'h00;
  localparam logic [4:0] IDX_PRIO9   = 5'h09;
  localparam logic [4:0] IDX_VBASE   = 5'h0a;
  localparam logic [4:0] IDX_FM0     = 5'h0b;
  localparam logic [4:0] IDX_FL0     = 5'h0c;
  localparam logic [4:0] IDX_FH0     = 5'h0d;
  localparam logic [4:0] IDX_FM1     = 5'h0e;
  localparam logic [4:0] IDX_FL1     = 5'h0f;
  localparam logic [4:0] IDX_FH1     = 5'h10;
  localparam logic [4:0] IDX_PEND0   = 5'h11;
  localparam logic [4:0] IDX_PEND2   = 5'h13;
  localparam logic [4:0] IDX_EN0     = 5'h17;
  localparam logic [4:0] IDX_EN2     = 5'h19;
  localparam logic [4:0] IDX_CTRL    = 5'h1d;
  // Writable bit masks
  localparam logic [31:0] MASK_PRIO  = 32'h0000ffff;
  localparam logic [31:0] MASK_VBASE = 32'h00003fff;
  localparam logic [31:0] MASK_FM    = 32'h0000007f;
  localparam logic [31:0] MASK_FL    = 32'h0000ffff;
  localparam logic [31:0] MASK_FH    = 32'h0000001f;
  localparam logic [31:0] MASK_EN    = 32'hffffffff;
  localparam logic [31:0] MASK_CTRL  = 32'h00000003;
  // Control fields: edge select for the two pins, level code read-only
  localparam int          CTRL_EDGE_A = 0;
  localparam int          CTRL_EDGE_B = 1;
  localparam int          CTRL_CODE   = 4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

//--- hdl/interrupt_arbiter.sv
// Prioritised interrupt arbiter with AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module interrupt_arbiter
  import irq_arb_pkg::*;
#(
  parameter int ADDR_W = 7
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_awaddr,
  input  wire logic                s_awvalid,
  output logic                     s_awready,
  input  wire logic [31:0]         s_wdata,
  input  wire logic [3:0]          s_wstrb,
  input  wire logic                s_wvalid,
  output logic                     s_wready,
  output logic [1:0]               s_bresp,
  output logic                     s_bvalid,
  input  wire logic                s_bready,
  input  wire logic [ADDR_W-1:0]   s_araddr,
  input  wire logic                s_arvalid,
  output logic                     s_arready,
  output logic [31:0]              s_rdata,
  output logic [1:0]               s_rresp,
  output logic                     s_rvalid,
  input  wire logic                s_rready,
  input  wire logic [NUM_SRC-1:0]  irq_src,
  input  wire logic                ext_irq_a_n,
  input  wire logic                ext_irq_b_n,
  input  wire logic [1:0]          core_mask,
  input  wire logic                irq_ack,
  input  wire logic                irq_return,
  input  wire logic                low_power,
  output logic                     irq_req,
  output logic [VADDR_W-1:0]       vector_addr,
  output logic                     vector_fast,
  output logic [1:0]               current_level_code,
  output logic                     boot_drive,
  output logic                     wake_req
);

  typedef struct packed {
    logic [31:0][31:0]    regs;
    logic                 aw_got;
    logic [4:0]           aw_idx;
    logic                 w_got;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 pin_a;
    logic                 pin_b;
    logic                 edge_a;
    logic                 edge_b;
    logic                 lp;
    logic [NUM_SRC-1:0]   wake_en;
    logic [1:0]           code;
    logic                 req;
    logic                 hold;
    logic [1:0]           lvl;
    logic [VEC_W-1:0]     idx;
    logic [VADDR_W-1:0]   addr;
    logic                 fast;
    logic                 boot;
  } state_t;

  state_t q, d;

  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] en;
  logic [NUM_SRC-1:0] act;
  logic               ext_a;
  logic               ext_b;
  logic               any;
  logic               win_ok;
  logic [1:0]         win_lvl;
  logic [VEC_W-1:0]   win_idx;
  logic [VEC_W-1:0]   cand;
  logic [1:0]         floor_lvl;
  logic [4:0]         ar_idx;
  logic [31:0]        bmask;

  // Priority of one source; the first sources are hard-wired
  function automatic logic [1:0] src_level(input state_t s, input int i);
    int k;
    k = i - FIXED_SRC;
    if (i < FIXED_SRC) begin
      return FIXED_LVL;
    end
    return s.regs[IDX_PRIO0 + 5'(k / 8)][(k % 8) * 2 +: 2];
  endfunction

  // Writable bits per register; zero means unmapped or read-only
  function automatic logic [31:0] wmask(input logic [4:0] i);
    if (i <= IDX_PRIO9) begin
      return MASK_PRIO;
    end
    unique case (i)
      IDX_VBASE:               return MASK_VBASE;
      IDX_FM0, IDX_FM1:        return MASK_FM;
      IDX_FL0, IDX_FL1:        return MASK_FL;
      IDX_FH0, IDX_FH1:        return MASK_FH;
      IDX_EN0, 5'h18, IDX_EN2: return MASK_EN;
      IDX_CTRL:                return MASK_CTRL;
      default:                 return 32'h00000000;
    endcase
  endfunction

  // Level code of a level as the core sees it
  function automatic logic [1:0] level_code(input logic [1:0] l);
    return (l == 2'h0) ? 2'h1 : (l == 2'h1) ? 2'h2 : 2'h3;
  endfunction

  // External pins: edge latch in run mode when its edge select bit is set, else plain low level, as while clocks sleep
  always_comb begin
    ext_a = (q.lp || !q.regs[IDX_CTRL][CTRL_EDGE_A]) ? !ext_irq_a_n : q.edge_a;
    ext_b = (q.lp || !q.regs[IDX_CTRL][CTRL_EDGE_B]) ? !ext_irq_b_n : q.edge_b;
    pend = irq_src;
    pend[EXT_A_SRC] = irq_src[EXT_A_SRC] | ext_a;
    pend[EXT_B_SRC] = irq_src[EXT_B_SRC] | ext_b;
    en = {q.regs[IDX_EN2][NUM_SRC-65:0], q.regs[5'h18], q.regs[IDX_EN0]};
    act = pend & en;
  end

  // Lowest admissible level: the stricter of core mask and current level
  always_comb begin
    floor_lvl = (core_mask > q.code) ? core_mask : q.code;
    win_ok = 1'b0;
    win_lvl = 2'h0;
    win_idx = '0;
    // Later (higher) levels override; descending scan keeps the lowest source
    for (int l = 0; l < 4; l++) begin
      any = 1'b0;
      cand = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (act[i] && src_level(q, i) == 2'(l)) begin
          any = 1'b1;
          cand = VEC_W'(i);
        end
      end
      if (any && 2'(l) >= floor_lvl) begin
        win_ok = 1'b1;
        win_lvl = 2'(l);
        win_idx = cand;
      end
    end
  end

  // Bus decode helpers
  always_comb begin
    ar_idx = s_araddr[6:2];
    for (int b = 0; b < 4; b++) begin
      bmask[b*8 +: 8] = {8{q.wstrb[b]}};
    end
  end

  // Next state
  always_comb begin
    d = q;
    // Write channel: address and data taken in either order
    if (s_awvalid && !q.aw_got) begin
      d.aw_got = 1'b1;
      d.aw_idx = s_awaddr[6:2];
    end
    if (s_wvalid && !q.w_got) begin
      d.w_got = 1'b1;
      d.wdata = s_wdata;
      d.wstrb = s_wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.regs[q.aw_idx] = (q.regs[q.aw_idx] & ~(bmask & wmask(q.aw_idx)))
                       | (q.wdata & bmask & wmask(q.aw_idx));
      d.bresp = (wmask(q.aw_idx) != 32'h0) ? RESP_OKAY : RESP_SLVERR;
      d.bvalid = 1'b1;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
    end
    if (q.bvalid && s_bready) begin
      d.bvalid = 1'b0;
    end
    // Read channel: one cycle to data; pending and control show live state
    if (s_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = q.regs[ar_idx] & wmask(ar_idx);
      if (ar_idx >= IDX_PEND0 && ar_idx <= IDX_PEND2) begin
        d.rdata = 32'({18'h0, pend} >> (32 * (ar_idx - IDX_PEND0)));
      end else if (ar_idx == IDX_CTRL) begin
        d.rdata[CTRL_CODE +: 2] = q.code;
      end else if (wmask(ar_idx) == 32'h0) begin
        d.rresp = RESP_SLVERR;
      end
    end
    if (q.rvalid && s_rready) begin
      d.rvalid = 1'b0;
    end
    // Falling-edge latches; a new edge wins over the acknowledge clear
    d.pin_a = ext_irq_a_n;
    d.pin_b = ext_irq_b_n;
    d.edge_a = (q.pin_a && !ext_irq_a_n)
             || (q.edge_a && !(irq_ack && q.req && q.idx == VEC_W'(EXT_A_SRC)));
    d.edge_b = (q.pin_b && !ext_irq_b_n)
             || (q.edge_b && !(irq_ack && q.req && q.idx == VEC_W'(EXT_B_SRC)));
    // Snapshot of enables at wait/stop entry
    d.lp = low_power;
    if (low_power && !q.lp) begin
      d.wake_en = en;
    end
    // Candidate to the core; paused two cycles after each acknowledge
    d.req = win_ok && !irq_ack && !q.hold;
    d.hold = irq_ack;
    d.lvl = win_lvl;
    d.idx = win_idx;
    d.fast = 1'b0;
    d.addr = {q.regs[IDX_VBASE][BASE_W-1:0], win_idx};
    if (win_lvl == 2'(FAST_LVL) && win_idx == q.regs[IDX_FM0][VEC_W-1:0]) begin
      d.fast = 1'b1;
      d.addr = {q.regs[IDX_FH0][4:0], q.regs[IDX_FL0][15:0]};
    end else if (win_lvl == 2'(FAST_LVL) && win_idx == q.regs[IDX_FM1][VEC_W-1:0]) begin
      d.fast = 1'b1;
      d.addr = {q.regs[IDX_FH1][4:0], q.regs[IDX_FL1][15:0]};
    end
    // Current level: entered on acknowledge, dropped on return (no stack)
    if (irq_ack && q.req) begin
      d.code = level_code(q.lvl);
    end else if (irq_return) begin
      d.code = 2'h0;
    end
    d.boot = 1'b0;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.pin_a <= 1'b1;
      q.pin_b <= 1'b1;
      q.boot <= 1'b1;
      q.addr <= RESET_ADDR;
    end else begin
      q <= d;
    end
  end

  // Outputs; handshakes direct from state, addresses from flops
  assign s_awready = !q.aw_got;
  assign s_wready = !q.w_got;
  assign s_bvalid = q.bvalid;
  assign s_bresp = q.bresp;
  assign s_arready = !q.rvalid;
  assign s_rvalid = q.rvalid;
  assign s_rdata = q.rdata;
  assign s_rresp = q.rresp;
  assign irq_req = q.req;
  assign vector_addr = q.boot ? RESET_ADDR : q.addr;
  assign vector_fast = q.fast;
  assign current_level_code = q.code;
  assign boot_drive = q.boot;
  assign wake_req = q.lp && |(pend & q.wake_en);

  // Checks
  a_mask_floor: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_req |-> q.lvl >= $past(core_mask)) else $error("request below core mask");
  a_nest_strict: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_req |-> q.lvl >= $past(q.code)) else $error("nesting not higher");
  a_code_ack: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_ack && irq_req && q.lvl == 2'h1 |=> current_level_code == 2'h2) else $error("bad level code");
  a_fast_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    vector_fast && q.idx == q.regs[IDX_FM0][VEC_W-1:0] && !q.boot
    |-> vector_addr == {q.regs[IDX_FH0][4:0], q.regs[IDX_FL0][15:0]}) else $error("fast address wrong");
  a_fast_level: assert property (@(posedge aclk) disable iff (!aresetn)
    vector_fast |-> q.lvl == 2'(FAST_LVL)) else $error("fast at wrong level");
  a_normal_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_req && !vector_fast && $stable(q.regs[IDX_VBASE])
    |-> vector_addr == {q.regs[IDX_VBASE][BASE_W-1:0], q.idx}) else $error("normal address wrong");
  sequence s_ack_taken;
    irq_ack && irq_req;
  endsequence
  a_one_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ack_taken |=> !irq_req ##1 !irq_req) else $error("second vector without pause");
  a_boot_addr: assert property (@(posedge aclk)
    $rose(aresetn) |-> boot_drive && vector_addr == RESET_ADDR ##1 !boot_drive) else $error("no boot address");
  a_wake_only_en: assert property (@(posedge aclk) disable iff (!aresetn)
    q.lp && $past(q.lp) |-> $stable(q.wake_en)) else $error("wake enables changed in sleep");
  a_wake_snap: assert property (@(posedge aclk) disable iff (!aresetn)
    low_power && !q.lp |=> q.wake_en == $past(en)) else $error("wake snapshot wrong");
  a_ext_level: assert property (@(posedge aclk) disable iff (!aresetn)
    q.lp && !ext_irq_a_n |-> pend[EXT_A_SRC]) else $error("pin not level in sleep");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    q.aw_got && q.w_got && !q.bvalid |=> s_bvalid) else $error("no write response");
  // Second pin, level return, read hold and quiet boot
  a_ext_b_level: assert property (@(posedge aclk) disable iff (!aresetn)
    q.lp && !ext_irq_b_n |-> pend[EXT_B_SRC]) else $error("pin b not level in sleep");
  a_level_return: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_return && !(irq_ack && q.req) |=> current_level_code == 2'h0) else $error("level kept after return");
  a_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)) else $error("read data not held");
  a_boot_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    boot_drive |-> !irq_req) else $error("request during boot");
endmodule

//--- sim/core_model.sv
// Behavioural core: takes presented vectors and returns from handlers
`timescale 1ns/1ns
module core_model
  import irq_arb_pkg::*;
#(
  parameter int HOLD = 8
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               serve,
  input  wire logic               slow,
  input  wire logic               irq_req,
  input  wire logic [VADDR_W-1:0] vector_addr,
  input  wire logic               vector_fast,
  output logic                    irq_ack,
  output logic                    irq_return,
  output logic [VADDR_W-1:0]      taken_addr,
  output logic                    taken_fast,
  output logic [7:0]              n_taken
);
  logic       busy_q;
  logic [3:0] cnt_q;

  // Ack one vector, run the handler for HOLD+1 cycles, then return; slow mode delays the ack
  always_ff @(posedge aclk) begin
    irq_ack <= 1'b0;
    irq_return <= 1'b0;
    if (!aresetn) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      n_taken <= 8'h00;
    end else if (!busy_q) begin
      if (serve && irq_req) begin
        if (cnt_q == (slow ? 4'h5 : 4'h0)) begin
          irq_ack <= 1'b1;
          taken_addr <= vector_addr;
          taken_fast <= vector_fast;
          n_taken <= n_taken + 8'h01;
          busy_q <= 1'b1;
          cnt_q <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end else if (cnt_q == 4'(HOLD)) begin
      irq_return <= 1'b1;
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

//--- sim/prioritized_interrupt_controller_tb.sv
// Self-checking bench for the interrupt arbiter
`timescale 1ns/1ns
module prioritized_interrupt_controller_tb;
  import irq_arb_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, ext_irq_a_n, ext_irq_b_n, irq_ack, irq_return, low_power;
  logic [3:0]         s_wstrb;
  logic irq_req, vector_fast, boot_drive, wake_req, serve, slow, taken_fast;
  logic [6:0]         s_awaddr, s_araddr;
  logic [31:0]        s_wdata, s_rdata;
  logic [1:0]         s_bresp, s_rresp, core_mask, current_level_code;
  logic [NUM_SRC-1:0] irq_src;
  logic [VADDR_W-1:0] vector_addr, taken_addr;
  logic [7:0]         n_taken;
  int                 n_errors = 0, checked = 0;

  interrupt_arbiter interrupt_arbiter_inst (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .irq_src(irq_src), .ext_irq_a_n(ext_irq_a_n), .ext_irq_b_n(ext_irq_b_n),
    .core_mask(core_mask), .irq_ack(irq_ack), .irq_return(irq_return), .low_power(low_power),
    .irq_req(irq_req), .vector_addr(vector_addr), .vector_fast(vector_fast),
    .current_level_code(current_level_code), .boot_drive(boot_drive), .wake_req(wake_req));
  core_model core_model_inst (.aclk(aclk), .aresetn(aresetn), .serve(serve), .slow(slow),
    .irq_req(irq_req), .vector_addr(vector_addr), .vector_fast(vector_fast), .irq_ack(irq_ack),
    .irq_return(irq_return), .taken_addr(taken_addr), .taken_fast(taken_fast), .n_taken(n_taken));

  // 125 MHz
  always #4 aclk = ~aclk;

  task automatic give_verdict;
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A stuck handshake ends the run rather than hanging it
  task automatic hang(input string nm);
    n_errors++;
    $display("[FAIL] %s expected done seen timeout", nm);
    give_verdict();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Both write halves offered together, each dropped once taken
  task automatic wr(input logic [4:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_awaddr <= {idx, 2'b00};
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid && n < 40);
    if (n >= 40) hang("write");
    s_bready <= 1'b0;
    chk("bresp", s_bresp, er);
  endtask

  task automatic rd(input logic [4:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_araddr <= {idx, 2'b00};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid && n < 40);
    if (n >= 40) hang("read");
    s_rready <= 1'b0;
    chk("rdata", s_rdata, ed);
    chk("rresp", s_rresp, er);
  endtask

  // Wait until the core model has taken one more vector
  task automatic take(input logic [7:0] prev);
    for (int n = 0; n < 300 && n_taken == prev; n++) @(posedge aclk);
    if (n_taken == prev) hang("take");
  endtask

  task automatic t_regs;
    wr(5'h1f, 32'h1, RESP_SLVERR);
    rd(5'h1f, 32'h0, RESP_SLVERR);
    wr(IDX_PEND0, 32'h1, RESP_SLVERR);
    wr(IDX_VBASE, 32'hffffffff, RESP_OKAY);
    rd(IDX_VBASE, 32'h00003fff, RESP_OKAY);
    // Byte strobe: only byte 1 is cleared
    s_wstrb <= 4'h2;
    wr(IDX_VBASE, 32'h00000000, RESP_OKAY);
    s_wstrb <= 4'hf;
    rd(IDX_VBASE, 32'h000000ff, RESP_OKAY);
    wr(IDX_VBASE, 32'h000002a5, RESP_OKAY);
  endtask

  // Sources 5,9 at level 1 and 20 at level 2, all raised together
  task automatic t_prio;
    logic [6:0] es [3] = '{7'd20, 7'd5, 7'd9};
    logic [1:0] ec [3] = '{2'b11, 2'b10, 2'b10};
    wr(IDX_PRIO0, 32'h00004040, RESP_OKAY);
    wr(5'h02, 32'h00000020, RESP_OKAY);
    wr(IDX_EN0, 32'h00100221, RESP_OKAY);
    irq_src[20] <= 1'b1;
    irq_src[9] <= 1'b1;
    irq_src[5] <= 1'b1;
    serve <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      take(n_taken);
      irq_src[es[k]] <= 1'b0;
      chk("vector", taken_addr, {14'h2a5, es[k]});
      chk("fast", taken_fast, 1'b0);
      tick(2);
      chk("level", current_level_code, ec[k]);
    end
    tick(12);
    chk("level_idle", current_level_code, 2'b00);
  endtask

  // Fast pair 1 on source 20, slow acknowledge
  task automatic t_fast;
    wr(IDX_FM1, 32'd20, RESP_OKAY);
    wr(IDX_FL1, 32'h00001234, RESP_OKAY);
    wr(IDX_FH1, 32'h00000005, RESP_OKAY);
    slow <= 1'b1;
    irq_src[20] <= 1'b1;
    take(n_taken);
    irq_src[20] <= 1'b0;
    chk("fast_addr", taken_addr, 21'h051234);
    chk("fast", taken_fast, 1'b1);
    tick(12);
    wr(5'h02, 32'h00000010, RESP_OKAY);
    irq_src[20] <= 1'b1;
    take(n_taken);
    irq_src[20] <= 1'b0;
    chk("vector", taken_addr, {14'h2a5, 7'd20});
    chk("fast", taken_fast, 1'b0);
    tick(14);
    // Both pairs match source 20; pair 0 is checked first
    wr(5'h02, 32'h00000020, RESP_OKAY);
    wr(IDX_FM0, 32'd20, RESP_OKAY);
    wr(IDX_FL0, 32'h0000abcd, RESP_OKAY);
    wr(IDX_FH0, 32'h00000003, RESP_OKAY);
    irq_src[20] <= 1'b1;
    take(n_taken);
    irq_src[20] <= 1'b0;
    chk("fast_addr0", taken_addr, 21'h03abcd);
    chk("fast0", taken_fast, 1'b1);
    tick(14);
    serve <= 1'b0;
    slow <= 1'b0;
  endtask

  // Every level of source 5 against every mask value
  task automatic t_mask;
    irq_src[5] <= 1'b1;
    for (int lv = 0; lv < 4; lv++) begin
      wr(IDX_PRIO0, 32'(lv) << 6, RESP_OKAY);
      for (int m = 0; m < 4; m++) begin
        core_mask <= 2'(m);
        tick(3);
        chk("req", irq_req, 32'(lv >= m));
      end
    end
    irq_src[5] <= 1'b0;
    irq_src[0] <= 1'b1;
    tick(3);
    chk("fixed_req", irq_req, 1'b1);
    chk("fixed_vec", vector_addr, {14'h2a5, 7'd0});
    irq_src[0] <= 1'b0;
    core_mask <= 2'b00;
  endtask

  // Only sources enabled before entry wake; pin A acts on level
  task automatic t_wake;
    wr(IDX_EN0, 32'h0000020c, RESP_OKAY);
    wr(IDX_CTRL, 32'h00000003, RESP_OKAY);
    low_power <= 1'b1;
    tick(3);
    chk("wake_idle", wake_req, 1'b0);
    wr(IDX_EN0, 32'h4000020c, RESP_OKAY);
    irq_src[30] <= 1'b1;
    tick(3);
    chk("wake_late", wake_req, 1'b0);
    irq_src[9] <= 1'b1;
    tick(3);
    chk("wake_src", wake_req, 1'b1);
    irq_src[9] <= 1'b0;
    tick(3);
    chk("wake_drop", wake_req, 1'b0);
    ext_irq_a_n <= 1'b0;
    tick(3);
    chk("wake_pin", wake_req, 1'b1);
    // Latched edge on pin A is ignored in sleep; pin B wakes on level
    ext_irq_a_n <= 1'b1;
    tick(3);
    chk("wake_pin_off", wake_req, 1'b0);
    ext_irq_b_n <= 1'b0;
    tick(3);
    chk("wake_pin_b", wake_req, 1'b1);
    low_power <= 1'b0;
  endtask

  // Main sequence
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, serve, slow, low_power} = '0;
    {s_awaddr, s_araddr, s_wdata, irq_src, core_mask} = '0;
    {ext_irq_a_n, ext_irq_b_n} = 2'h3;
    s_wstrb = 4'hf;
    tick(12);
    chk("boot", boot_drive, 1'b1);
    chk("boot_addr", vector_addr, RESET_ADDR);
    chk("req_rst", irq_req, 1'b0);
    aresetn <= 1'b1;
    tick(4);
    chk("boot_end", boot_drive, 1'b0);
    t_regs();
    t_prio();
    t_fast();
    t_mask();
    t_wake();
    give_verdict();
  end
endmodule
